// >>> smh_cfg.svh
// offsets, field positions, reset values and timing figures of the serial host
// assumes inclusion by bare name from every design file that needs them
`ifndef SMH_CFG_SVH
`define SMH_CFG_SVH

// register offsets on the plain command port
`define SMH_A_CTRL     4'h0
`define SMH_A_DIV      4'h1
`define SMH_A_TX       4'h2
`define SMH_A_RX       4'h3
`define SMH_A_STAT     4'h4

// control register fields
`define SMH_B_EN       0
`define SMH_B_POL      1
`define SMH_B_PHASE    2
`define SMH_B_HOLD     3
`define SMH_B_SIMPLEX  4

// status register fields
`define SMH_S_BUSY     0
`define SMH_S_DONE     1
`define SMH_S_REFUSED  2
`define SMH_S_SS       3

// reset values
`define SMH_CTRL_RST   5'h00
`define SMH_DIV_RST    8'h10

// timing
`define SMH_CLK_NS     10
// a pin change reaches the sequencer's logic four edges later and is captured on the fifth
`define SMH_SYNC_LAT   5
`define SMH_LAST_EDGE  4'hf

`endif

// >>> smh_dev_model.sv
// far serial port modelled as an enabled slave with a preloaded byte
// assumes the bench sets polarity, phase and byte before the select falls
`timescale 1ns/1ps
module smh_dev_model (
  // serial pins
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ss_n,
  output logic            o_miso,
  // far software settings
  input  wire logic       i_clock_idle_polarity,
  input  wire logic       i_capture_edge_phase,
  input  wire logic [7:0] i_tx,
  // last byte taken in
  output logic      [7:0] o_rx
);
  logic [7:0] sh = 8'h00;
  logic       out_q = 1'b0;
  logic       sel = 1'b0;
  logic       lead;
  int         nbit = 0;
  int         n_bytes = 0;

  // far master mode and flag clearing by far software are not modelled

  ////////////////////////////////////////////////////////////////////////////
  // byte loaded at select, msb ready there only for first-edge phase
  // select follows the pin, management bit clear
  always @(negedge i_ss_n) begin
    sel = 1'b1;
    nbit = 0;
    sh = i_tx;
    if (!i_capture_edge_phase) begin
      out_q = i_tx[7];
    end
  end
  // late release so a last capture edge in the same step still counts
  always @(posedge i_ss_n) begin
    #1;
    sel = 1'b0;
    o_rx = sh;
  end
  // capture and launch on opposite edges
  always @(i_sck) begin
    if (sel) begin
      lead = (i_sck !== i_clock_idle_polarity);
      if (lead ^ i_capture_edge_phase) begin
        sh = {sh[6:0], i_mosi};
        nbit = nbit + 1;
        // byte end counted after eight captures
        if (nbit == 8) begin
          nbit = 0;
          n_bytes = n_bytes + 1;
        end
      end else begin
        out_q = sh[7];
      end
    end
  end
  // released line shows the inverse of its last bit
  // slave only: never drives the clock
  assign o_miso = sel ? out_q : ~out_q;
endmodule : smh_dev_model

// >>> smh_host.sv
// serial master that drives an 8-bit serial port set up as a slave
// assumes the far port is enabled as slave with the same polarity and phase
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "smh_cfg.svh"
module smh_host #(
  parameter int DEV_CPU_NS = 125,
  parameter int GAP_NS     = 1000
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // command port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // serial pins
  input  wire logic       i_miso,
  input  wire logic       i_mosi,
  output logic            o_sck,
  output logic            o_mosi,
  output logic            o_mosi_oe_n,
  output logic            o_ss_n
);

  ////////////////////////////////////////////////////////////////////////////
  // timing limits
  localparam int HALF_DEV = (DEV_CPU_NS + `SMH_CLK_NS - 1) / `SMH_CLK_NS;
  localparam int HALF_MIN = (HALF_DEV > `SMH_SYNC_LAT) ? HALF_DEV : `SMH_SYNC_LAT;
  localparam int GAP_RAW  = (GAP_NS + `SMH_CLK_NS - 1) / `SMH_CLK_NS;
  localparam int GAP_CYC  = (GAP_RAW < 1) ? 1 : GAP_RAW;

  generate
    if (HALF_MIN > 255 || GAP_CYC > 255) begin : g_bad_timing
      $error("smh_host: timing does not fit 8-bit counters");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers
  smh_pkg::smh_state_type state_r;
  smh_pkg::smh_state_type state_nxt;
  smh_pkg::smh_ctrl_type  ctrl_r;
  smh_pkg::smh_pins_type  pins_r;
  smh_pkg::smh_pins_type  pins_nxt;
  logic [7:0] div_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [3:0] edge_r;
  logic [3:0] edge_nxt;
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  logic       done_r;
  logic       refused_r;
  logic       done_p;
  logic [7:0] rdata_r;
  logic       tick;
  logic       miso_lvl;
  logic       mosi_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire idle      = (state_r == smh_pkg::SMH_IDLE);
  wire wr_ctrl   = i_wr && (i_addr == `SMH_A_CTRL);
  wire wr_div    = i_wr && (i_addr == `SMH_A_DIV);
  wire wr_tx     = i_wr && (i_addr == `SMH_A_TX);
  wire rd_stat   = i_rd && (i_addr == `SMH_A_STAT);
  wire ctrl_ok   = wr_ctrl && idle;
  wire div_ok    = wr_div && idle;
  wire start     = wr_tx && idle && ctrl_r.en;
  wire refuse_p  = (wr_tx && !start) || (wr_ctrl && !idle) || (wr_div && !idle);
  wire pol_chg   = ctrl_ok && (i_wdata[`SMH_B_POL] != ctrl_r.clock_idle_polarity);
  wire cap_edge  = (edge_r[0] == ctrl_r.capture_edge_phase);
  wire rx_bit    = ctrl_r.simplex ? mosi_lvl : miso_lvl;
  wire [7:0] sh_cap = {sh_r[6:0], rx_bit};
  wire last_edge = (edge_r == `SMH_LAST_EDGE);
  wire gap_end   = (gap_r == 8'(GAP_CYC - 1));
  // hold select only for second-edge phase
  wire keep_low  = ctrl_r.en && ctrl_r.capture_edge_phase && ctrl_r.hold && !pol_chg;
  wire [7:0] half_eff = (div_r < 8'(HALF_MIN)) ? 8'(HALF_MIN) : div_r;
  wire [7:0] stat_val = {4'h0, pins_r.ss_n, refused_r, done_r, !idle};

  wire [7:0] rdata_nxt =
      !i_rd                      ? 8'h00 :
      (i_addr == `SMH_A_CTRL)    ? {3'h0, ctrl_r} :
      (i_addr == `SMH_A_DIV)     ? div_r :
      (i_addr == `SMH_A_RX)      ? rx_r :
      (i_addr == `SMH_A_STAT)    ? stat_val :
                                   8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  smh_sync u_sync_miso (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_miso),
    .o_level (miso_lvl)
  );

  smh_sync u_sync_mosi (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_mosi),
    .o_level (mosi_lvl)
  );

  // half period never below one far CPU period
  smh_tick #(.W(8)) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_run   (state_r == smh_pkg::SMH_LEAD || state_r == smh_pkg::SMH_SHIFT),
    .i_half  (half_eff),
    .o_tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_comb begin
    state_nxt = state_r;
    pins_nxt  = pins_r;
    sh_nxt    = sh_r;
    rx_nxt    = rx_r;
    edge_nxt  = edge_r;
    gap_nxt   = gap_r;
    done_p    = 1'b0;
    // shared data line is released in simplex mode
    pins_nxt.mosi_oe_n = !(ctrl_r.en && !ctrl_r.simplex);
    case (state_r)
      smh_pkg::SMH_IDLE: begin
        pins_nxt.sck = ctrl_r.clock_idle_polarity;
        // select high unless a message is held open
        if (!keep_low) begin
          pins_nxt.ss_n = 1'b1;
        end
        // each byte starts on a software data write
        if (start) begin
          state_nxt     = smh_pkg::SMH_LEAD;
          sh_nxt        = i_wdata;
          pins_nxt.mosi = i_wdata[7];
          pins_nxt.ss_n = 1'b0;
          edge_nxt      = 4'h0;
        end
      end
      smh_pkg::SMH_LEAD: begin
        if (tick) begin
          state_nxt = smh_pkg::SMH_SHIFT;
        end
      end
      smh_pkg::SMH_SHIFT: begin
        if (tick) begin
          pins_nxt.sck = !pins_r.sck;
          edge_nxt     = edge_r + 4'h1;
          // sample on capture edge, drive on the other
          if (cap_edge) begin
            sh_nxt = sh_cap;
          end else begin
            pins_nxt.mosi = sh_r[7];
          end
          if (last_edge) begin
            rx_nxt    = cap_edge ? sh_cap : sh_r;
            done_p    = 1'b1;
            state_nxt = smh_pkg::SMH_GAP;
            gap_nxt   = 8'h00;
            if (!(ctrl_r.capture_edge_phase && ctrl_r.hold)) begin
              pins_nxt.ss_n = 1'b1;
            end
          end
        end
      end
      smh_pkg::SMH_GAP: begin
        // spacing lets far software clear its flag
        gap_nxt = gap_r + 8'h01;
        if (gap_end) begin
          state_nxt = smh_pkg::SMH_IDLE;
        end
      end
      default: begin
        state_nxt = smh_pkg::SMH_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= smh_pkg::SMH_IDLE;
      pins_r  <= 4'b0011;
      sh_r    <= 8'h00;
      rx_r    <= 8'h00;
      edge_r  <= 4'h0;
      gap_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      pins_r  <= pins_nxt;
      sh_r    <= sh_nxt;
      rx_r    <= rx_nxt;
      edge_r  <= edge_nxt;
      gap_r   <= gap_nxt;
    end
  end

  // settings change only while idle, before any start
  // far slave waits for our start after its own setup
  // polarity write also drops a held select first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= `SMH_CTRL_RST;
      div_r  <= `SMH_DIV_RST;
    end else begin
      if (ctrl_ok) begin
        ctrl_r <= i_wdata[4:0];
      end
      if (div_ok) begin
        div_r <= i_wdata;
      end
    end
  end

  // sticky flags: a new event beats the clearing status read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      done_r    <= done_p || (done_r && !rd_stat);
      refused_r <= refuse_p || (refused_r && !rd_stat);
      rdata_r   <= rdata_nxt;
    end
  end

  assign o_sck       = pins_r.sck;
  assign o_mosi      = pins_r.mosi;
  assign o_mosi_oe_n = pins_r.mosi_oe_n;
  assign o_ss_n      = pins_r.ss_n;
  assign o_rdata     = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] age_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_r <= 8'h00;
    end else if (pins_nxt.sck != pins_r.sck) begin
      age_r <= 8'h00;
    end else if (age_r != 8'hff) begin
      age_r <= age_r + 8'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_sck_half_min: assert property (
    (state_r == smh_pkg::SMH_SHIFT && tick) |-> age_r >= 8'(HALF_MIN - 1))
    else $error("serial clock half period too short");

  a_idle_clock_level: assert property (
    (idle && $past(idle) && !$past(pol_chg)) |-> o_sck == ctrl_r.clock_idle_polarity)
    else $error("idle clock not at polarity level");

  a_select_off_high: assert property (
    (idle && !ctrl_r.en) |=> o_ss_n)
    else $error("select low while disabled");

  a_select_held_shift: assert property (
    (state_r == smh_pkg::SMH_SHIFT) |-> !o_ss_n)
    else $error("select high inside a byte");

  a_select_gap_rise: assert property (
    (done_p && !ctrl_r.capture_edge_phase) |=> o_ss_n ##1 o_ss_n)
    else $error("select not raised between bytes");

  a_byte_edges_even: assert property (
    done_p |=> o_sck == ctrl_r.clock_idle_polarity)
    else $error("clock not back at idle after byte");

  a_mosi_capture_stable: assert property (
    (state_r == smh_pkg::SMH_SHIFT && tick && cap_edge) |=> $stable(o_mosi))
    else $error("data moved on capture edge");

  a_simplex_release: assert property (
    ctrl_r.simplex |=> o_mosi_oe_n)
    else $error("shared line still driven in simplex");

  a_pol_change_release: assert property (
    pol_chg |=> o_ss_n)
    else $error("polarity changed with select low");

  a_gap_spacing: assert property (
    done_p |=> !idle [*2])
    else $error("next byte started without gap");

  c_phase0_byte: cover property (done_p && !ctrl_r.capture_edge_phase);
  c_phase1_held: cover property (done_p && ctrl_r.capture_edge_phase && ctrl_r.hold);
  c_simplex_byte: cover property (done_p && ctrl_r.simplex);
  c_refused_write: cover property (refuse_p && wr_tx);

endmodule : smh_host

// >>> smh_pkg.sv
// types shared by the serial host modules
// assumes nothing beyond a SystemVerilog compiler
package smh_pkg;

  typedef enum logic [3:0] {
    SMH_IDLE  = 4'b0001,
    SMH_LEAD  = 4'b0010,
    SMH_SHIFT = 4'b0100,
    SMH_GAP   = 4'b1000
  } smh_state_type;

  typedef struct packed {
    logic simplex;
    logic hold;
    logic capture_edge_phase;
    logic clock_idle_polarity;
    logic en;
  } smh_ctrl_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic mosi_oe_n;
    logic ss_n;
  } smh_pins_type;

endpackage : smh_pkg

// >>> smh_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin on i_pin and i_clk as the only clock
`timescale 1ns/1ps
module smh_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // first stage feeds only the second one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign o_level = level_r;

endmodule : smh_sync

// >>> smh_tick.sv
// half-period tick generator for the serial clock
// assumes i_half is held steady while i_run is high
`timescale 1ns/1ps
module smh_tick #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // control
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_half,
  // one-cycle pulse every i_half cycles
  output logic              o_tick
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;
  wire          wrap = (cnt_r == i_half - W'(1));

  generate
    if (W < 2) begin : g_bad_width
      $error("smh_tick: width below 2");
    end
  endgenerate

  assign cnt_nxt  = !i_run ? '0 : (wrap ? '0 : cnt_r + W'(1));
  assign tick_nxt = i_run & wrap;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end

endmodule : smh_tick

// >>> tb_top.sv
// bench for the serial host: register tasks against one far slave model
// assumes smh_host, smh_dev_model and smh_cfg.svh compiled alongside
`timescale 1ns/1ps
`include "smh_cfg.svh"
module tb_top;
  logic       i_clk;
  logic       i_rst_n;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       o_sck;
  logic       o_mosi;
  logic       o_mosi_oe_n;
  logic       o_ss_n;
  logic       dev_miso;
  logic       mosi_line;
  logic       dev_clock_idle_polarity;
  logic       dev_capture_edge_phase;
  logic [7:0] dev_tx;
  logic [7:0] dev_rx;
  int         n_fail;
  int         samples_checked;
  logic [7:0] hb [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h81};
  logic [7:0] db [4] = '{8'h96, 8'h0F, 8'hE7, 8'h42};

  // shared data line once the host lets go of it
  assign mosi_line = o_mosi_oe_n ? dev_miso : o_mosi;

  smh_host #(.DEV_CPU_NS(40), .GAP_NS(20)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_miso(dev_miso),
    .i_mosi(mosi_line), .o_sck(o_sck), .o_mosi(o_mosi),
    .o_mosi_oe_n(o_mosi_oe_n), .o_ss_n(o_ss_n));

  smh_dev_model dev (
    .i_sck(o_sck), .i_mosi(mosi_line), .i_ss_n(o_ss_n), .o_miso(dev_miso),
    .i_clock_idle_polarity(dev_clock_idle_polarity), .i_capture_edge_phase(dev_capture_edge_phase), .i_tx(dev_tx), .o_rx(dev_rx));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, exp);
  endtask : rd

  // bounded wait for select release, then the idle gap
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_ss_n !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_fail++;
      $display("mismatch at %0t: select never released", $time);
      test_done();
    end
    repeat (4) @(posedge i_clk);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    dev_clock_idle_polarity = 1'b0;
    dev_capture_edge_phase = 1'b0;
    dev_tx = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk({5'h00, o_sck, o_mosi_oe_n, o_ss_n}, 8'h03);
    rd(`SMH_A_CTRL, 8'h00);
    rd(`SMH_A_DIV, 8'h10);
    rd(`SMH_A_STAT, 8'h08);
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h00);
    // below the floor, so the far slave clock limit still holds
    wr(`SMH_A_DIV, 8'h03);
    rd(`SMH_A_DIV, 8'h03);
    wr(`SMH_A_TX, 8'h11);
    rd(`SMH_A_STAT, 8'h0C);
    rd(`SMH_A_STAT, 8'h08);
    for (int m = 0; m < 4; m++) begin
      dev_clock_idle_polarity <= m[0];
      dev_capture_edge_phase <= m[1];
      dev_tx   <= db[m];
      wr(`SMH_A_CTRL, {5'h00, m[1], m[0], 1'b1});
      repeat (3) @(negedge i_clk);
      chk({7'h00, o_sck}, {7'h00, m[0]});
      wr(`SMH_A_TX, hb[m]);
      wait_idle();
      chk(dev_rx, hb[m]);
      rd(`SMH_A_RX, db[m]);
      rd(`SMH_A_STAT, 8'h0A);
      rd(`SMH_A_STAT, 8'h08);
    end
    dev_tx <= 8'h5C;
    wr(`SMH_A_TX, 8'h66);
    wr(`SMH_A_TX, 8'h99);
    rd(`SMH_A_STAT, 8'h05);
    wait_idle();
    chk(dev_rx, 8'h66);
    rd(`SMH_A_RX, 8'h5C);
    dev_clock_idle_polarity <= 1'b0;
    dev_capture_edge_phase <= 1'b1;
    dev_tx   <= 8'h3C;
    wr(`SMH_A_CTRL, 8'h0D);
    wr(`SMH_A_TX, 8'hB4);
    repeat (90) @(negedge i_clk);
    chk({7'h00, o_ss_n}, 8'h00);
    rd(`SMH_A_STAT, 8'h02);
    wr(`SMH_A_CTRL, 8'h05);
    repeat (3) @(negedge i_clk);
    chk({7'h00, o_ss_n}, 8'h01);
    chk(dev_rx, 8'hB4);
    rd(`SMH_A_RX, 8'h3C);
    dev_capture_edge_phase <= 1'b0;
    dev_tx   <= 8'hC6;
    wr(`SMH_A_CTRL, 8'h11);
    wr(`SMH_A_TX, 8'h00);
    repeat (20) @(negedge i_clk);
    chk({7'h00, o_mosi_oe_n}, 8'h01);
    wait_idle();
    rd(`SMH_A_RX, 8'hC6);
    chk(8'(dev.n_bytes), 8'h07);
    test_done();
  end
endmodule : tb_top
